//--- rtl/cbc_cfg.svh
/*
 * Offsets, opcodes and field positions of the branch/compare unit.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef CBC_CFG_SVH
`define CBC_CFG_SVH
// ----------------------------------------
// Opcodes
// ----------------------------------------
`define CBC_OP_BNZ  8'hF2
`define CBC_OP_BZ   8'hE2
`define CBC_OP_BVI  8'hF7
`define CBC_OP_BVV  8'hE7
`define CBC_OP_CAL  8'h52
`define CBC_OP_CIL  8'h72
`define CBC_OP_CAX  8'h82
`define CBC_OP_CAI  8'h92
`define CBC_OP_CII  8'hB2
`define CBC_OP_ADC  8'h57
// ----------------------------------------
// Register offsets and fields
// ----------------------------------------
`define CBC_REG_CTRL   8'h00
`define CBC_REG_PC     8'h04
`define CBC_REG_ACC    8'h08
`define CBC_REG_IDX    8'h0C
`define CBC_REG_FLAGS  8'h10
`define CBC_REG_STATUS 8'h14
`define CBC_CTRL_RUN   0
`define CBC_FLG_C      0
`define CBC_FLG_E      1
`define CBC_FLG_Z      2
`define CBC_FLG_S      3
`define CBC_FLG_V      4
`define CBC_STAT_BUSY  0
`define CBC_STAT_ILL   1
`define CBC_RESP_OK    2'h0
`define CBC_RESP_ERR   2'h2
`endif

//--- rtl/cbc_pkg.sv
/*
 * Types of the branch/compare unit.
 * Assumes nothing of its surroundings.
 */
`default_nettype none
package cbc_pkg;
    // ----------------------------------------
    // Sequencer states
    // ----------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_OP   = 4'h2,
        ST_ARG  = 4'h4,
        ST_LCT  = 4'h8
    } cbc_state_t;
endpackage : cbc_pkg
`default_nettype wire

//--- rtl/cbc_unit.sv
/* Channel program branch/compare/add-with-carry executor, AXI4-Lite slave.
 * Assumes combinational program and table stores on the same clock. */
// Summary of operation
// - Branch displacement is a signed byte relative to the operand byte.
// - Branch-if-not-zero F2 jumps when zero is clear, else steps one.
// - Branch-if-zero E2 jumps when zero is set, else steps one.
// - Status branches are the zero branches, testing only zero.
// - Branch-if-block-invalid F7 jumps when valid-block flag is clear.
// - Branch-if-block-valid E7 jumps when valid-block flag is set.
// - Of the opcodes only add-with-carry updates zero; compares and conditional branches leave it alone.
// - Cancel clears zero when a character goes, sets it otherwise.
// - Hand-over clears zero when a block goes, sets it otherwise.
// - Compares subtract, store nothing, set carry and equal from result.
// - Opcode 52 compares accumulator with a table byte.
// - Opcode 72 compares index register with a table byte.
// - Opcode 82 compares accumulator with table byte addressed by index.
// - Opcode 92 compares accumulator with an inline byte.
// - Opcode B2 compares index register with an inline byte.
// - Opcode 57 adds accumulator, carry and a table byte into accumulator.
// - Carry propagates so multi-byte sums work.
// - Add-with-carry sets carry, sign and zero from its result.
`include "cbc_cfg.svh"
`default_nettype none
module cbc_unit
    import cbc_pkg::*;
#(
    parameter int PC_W = 16
) (
    input  wire logic            clk_sys,
    input  wire logic            reset,
    input  wire logic [7:0]      s_axi_awaddr,
    input  wire logic            s_axi_awvalid,
    output logic                 s_axi_awready,
    input  wire logic [31:0]     s_axi_wdata,
    input  wire logic [3:0]      s_axi_wstrb,
    input  wire logic            s_axi_wvalid,
    output logic                 s_axi_wready,
    output logic [1:0]           s_axi_bresp,
    output logic                 s_axi_bvalid,
    input  wire logic            s_axi_bready,
    input  wire logic [7:0]      s_axi_araddr,
    input  wire logic            s_axi_arvalid,
    output logic                 s_axi_arready,
    output logic [31:0]          s_axi_rdata,
    output logic [1:0]           s_axi_rresp,
    output logic                 s_axi_rvalid,
    input  wire logic            s_axi_rready,
    output logic [PC_W-1:0]      prog_addr,
    output logic                 prog_rd,
    input  wire logic [7:0]      prog_data,
    output logic [7:0]           lct_addr,
    output logic                 lct_rd,
    input  wire logic [7:0]      lct_data,
    input  wire logic            valid_block_flag,
    input  wire logic            zero_upd_valid,
    input  wire logic            zero_upd_value,
    input  wire logic            cancel_evt,
    input  wire logic            cancel_done,
    input  wire logic            handover_evt,
    input  wire logic            handover_done,
    output logic [7:0]           acc_out,
    output logic [7:0]           idx_out,
    output logic                 carry_flag,
    output logic                 equal_flag,
    output logic                 zero_flag,
    output logic                 sign_flag
);
    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    function automatic logic is_branch(input logic [7:0] op);
        return op == `CBC_OP_BNZ || op == `CBC_OP_BZ ||
               op == `CBC_OP_BVI || op == `CBC_OP_BVV;
    endfunction : is_branch
    function automatic logic uses_lct(input logic [7:0] op);
        return op == `CBC_OP_CAL || op == `CBC_OP_CIL || op == `CBC_OP_ADC;
    endfunction : uses_lct
    function automatic logic is_imm(input logic [7:0] op);
        return op == `CBC_OP_CAI || op == `CBC_OP_CII;
    endfunction : is_imm
    function automatic logic reg_ok(input logic [7:0] a);
        return a == `CBC_REG_CTRL || a == `CBC_REG_PC || a == `CBC_REG_ACC ||
               a == `CBC_REG_IDX || a == `CBC_REG_FLAGS || a == `CBC_REG_STATUS;
    endfunction : reg_ok
    cbc_state_t      st_r;
    logic [PC_W-1:0] pc_r;
    logic [7:0]      op_r, acc_r, idx_r, awaddr_r;
    logic            c_r, e_r, z_r, s_r, run_r, ill_r, aw_full_r, w_full_r, wstrb0_r;
    logic [31:0]     wdata_r;
    // ----------------------------------------
    // Datapath
    // ----------------------------------------
    // The operand byte sits at pc+1, so the target is pc+1+disp.
    logic [PC_W-1:0] pc_tgt, pc_skip;
    logic            br_take, halted, exec_cmp, exec_add, wr_fire, sw_wr, op_unk;
    logic [7:0]      lhs, rhs;
    logic [8:0]      cmp_sum, add_sum;
    assign pc_tgt   = pc_r + PC_W'(1) + {{(PC_W-8){prog_data[7]}}, prog_data};
    assign pc_skip  = pc_r + PC_W'(2);
    assign br_take  = (op_r == `CBC_OP_BNZ && !z_r) || (op_r == `CBC_OP_BZ && z_r) ||
                      (op_r == `CBC_OP_BVI && !valid_block_flag) ||
                      (op_r == `CBC_OP_BVV && valid_block_flag);
    assign halted   = !run_r && st_r == ST_IDLE;
    assign lhs      = (op_r == `CBC_OP_CIL || op_r == `CBC_OP_CII) ? idx_r : acc_r;
    assign rhs      = is_imm(op_r) ? prog_data : lct_data;
    assign cmp_sum  = {1'b0, lhs} + {1'b0, ~rhs} + 9'h001;
    assign add_sum  = {1'b0, acc_r} + {1'b0, rhs} + {8'h00, c_r};
    assign exec_cmp = (st_r == ST_ARG && is_imm(op_r)) ||
                      (st_r == ST_LCT && op_r != `CBC_OP_ADC);
    assign exec_add = st_r == ST_LCT && op_r == `CBC_OP_ADC;
    assign wr_fire  = aw_full_r && w_full_r && !s_axi_bvalid;
    assign sw_wr    = wr_fire && halted && wstrb0_r;
    assign op_unk   = !is_branch(prog_data) && !uses_lct(prog_data) && !is_imm(prog_data) &&
                      prog_data != `CBC_OP_CAX;
    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    // Opcode fetch, then operand fetch (skipped for 82), then an optional table read.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st_r <= ST_IDLE;
        end else begin
            unique case (st_r)
                ST_IDLE: if (run_r) st_r <= ST_OP;
                ST_OP:   st_r <= (prog_data == `CBC_OP_CAX) ? ST_LCT :
                                 (op_unk ? ST_IDLE : ST_ARG);
                ST_ARG:  st_r <= uses_lct(op_r) ? ST_LCT : ST_IDLE;
                ST_LCT:  st_r <= ST_IDLE;
                default: st_r <= ST_IDLE;
            endcase
        end
    end
    // Store strobes; data is read in the cycle the strobe is high.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            prog_rd   <= 1'b0;
            prog_addr <= '0;
            lct_rd    <= 1'b0;
            lct_addr  <= 8'h00;
            op_r      <= 8'h00;
        end else begin
            prog_rd <= (st_r == ST_IDLE && run_r) ||
                       (st_r == ST_OP && !op_unk && prog_data != `CBC_OP_CAX);
            prog_addr <= (st_r == ST_IDLE) ? pc_r : pc_r + PC_W'(1);
            lct_rd <= (st_r == ST_OP && prog_data == `CBC_OP_CAX) ||
                      (st_r == ST_ARG && uses_lct(op_r));
            lct_addr <= (st_r == ST_OP) ? idx_r : prog_data;
            if (st_r == ST_OP) op_r <= prog_data;
        end
    end
    // Program pointer.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pc_r <= '0;
        end else if (sw_wr && awaddr_r == `CBC_REG_PC) begin
            pc_r <= wdata_r[PC_W-1:0];
        end else if (st_r == ST_OP && op_unk) begin
            pc_r <= pc_r + PC_W'(1);
        end else if (st_r == ST_ARG && is_branch(op_r)) begin
            pc_r <= br_take ? pc_tgt : pc_skip;
        end else if (st_r == ST_ARG && is_imm(op_r)) begin
            pc_r <= pc_skip;
        end else if (st_r == ST_LCT) begin
            pc_r <= (op_r == `CBC_OP_CAX) ? pc_r + PC_W'(1) : pc_skip;
        end
    end
    // Indicators. Branches never touch them; own results beat outside reports.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            c_r <= 1'b0;
            e_r <= 1'b0;
            z_r <= 1'b0;
            s_r <= 1'b0;
        end else if (sw_wr && awaddr_r == `CBC_REG_FLAGS) begin
            c_r <= wdata_r[`CBC_FLG_C];
            e_r <= wdata_r[`CBC_FLG_E];
            z_r <= wdata_r[`CBC_FLG_Z];
            s_r <= wdata_r[`CBC_FLG_S];
        end else if (exec_cmp) begin
            c_r <= cmp_sum[8];
            e_r <= cmp_sum[7:0] == 8'h00;
            z_r <= cancel_evt ? !cancel_done : handover_evt ? !handover_done :
                   zero_upd_valid ? zero_upd_value : z_r;
        end else if (exec_add) begin
            c_r <= add_sum[8];
            s_r <= add_sum[7];
            z_r <= add_sum[7:0] == 8'h00;
        end else if (cancel_evt) begin
            z_r <= !cancel_done;
        end else if (handover_evt) begin
            z_r <= !handover_done;
        end else if (zero_upd_valid) begin
            z_r <= zero_upd_value;
        end
    end
    // Working registers; compares leave both untouched.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            acc_r <= 8'h00;
            idx_r <= 8'h00;
        end else if (exec_add) begin
            acc_r <= add_sum[7:0];
        end else if (sw_wr && awaddr_r == `CBC_REG_ACC) begin
            acc_r <= wdata_r[7:0];
        end else if (sw_wr && awaddr_r == `CBC_REG_IDX) begin
            idx_r <= wdata_r[7:0];
        end
    end
    // Run control and sticky illegal-opcode flag; a new set beats the clear.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            run_r <= 1'b0;
            ill_r <= 1'b0;
        end else begin
            if (wr_fire && wstrb0_r && awaddr_r == `CBC_REG_CTRL)
                run_r <= wdata_r[`CBC_CTRL_RUN];
            if (st_r == ST_OP && op_unk)
                ill_r <= 1'b1;
            else if (wr_fire && wstrb0_r && awaddr_r == `CBC_REG_STATUS &&
                     wdata_r[`CBC_STAT_ILL])
                ill_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------
    // Address and data are caught separately; the response follows both.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `CBC_RESP_OK;
            aw_full_r     <= 1'b0;
            w_full_r      <= 1'b0;
            awaddr_r      <= 8'h00;
            wdata_r       <= 32'h0000_0000;
            wstrb0_r      <= 1'b0;
        end else begin
            s_axi_awready <= !s_axi_awready && s_axi_awvalid && !aw_full_r;
            s_axi_wready  <= !s_axi_wready && s_axi_wvalid && !w_full_r;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_r <= 1'b1;
                wdata_r  <= s_axi_wdata;
                wstrb0_r <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_full_r    <= 1'b0;
                w_full_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= reg_ok(awaddr_r) ? `CBC_RESP_OK : `CBC_RESP_ERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    // Read path; one read outstanding at a time.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `CBC_RESP_OK;
        end else begin
            s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= reg_ok(s_axi_araddr) ? `CBC_RESP_OK : `CBC_RESP_ERR;
                unique case (s_axi_araddr)
                    `CBC_REG_CTRL:   s_axi_rdata <= {31'h0, run_r};
                    `CBC_REG_PC:     s_axi_rdata <= 32'(pc_r);
                    `CBC_REG_ACC:    s_axi_rdata <= {24'h0, acc_r};
                    `CBC_REG_IDX:    s_axi_rdata <= {24'h0, idx_r};
                    `CBC_REG_FLAGS:  s_axi_rdata <= {27'h0, valid_block_flag, s_r, z_r,
                                                      e_r, c_r};
                    `CBC_REG_STATUS: s_axi_rdata <= {30'h0, ill_r, st_r != ST_IDLE};
                    default:         s_axi_rdata <= 32'h0000_0000;
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Outputs and checks
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            {acc_out, idx_out, carry_flag, equal_flag, zero_flag, sign_flag} <= 20'h0_0000;
        end else begin
            {acc_out, idx_out, carry_flag, equal_flag, zero_flag, sign_flag} <=
                {acc_r, idx_r, c_r, e_r, z_r, s_r};
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    sequence seq_idx_fetch;
        st_r == ST_OP && prog_data == `CBC_OP_CAX ##1 st_r == ST_LCT;
    endsequence
    a_bnz_target: assert property (st_r == ST_ARG && op_r == `CBC_OP_BNZ && !z_r
        |=> pc_r == $past(pc_tgt)) else $error("not-zero branch missed target");
    a_bz_target: assert property (st_r == ST_ARG && op_r == `CBC_OP_BZ && z_r
        |=> pc_r == $past(pc_tgt)) else $error("zero branch missed target");
    a_bvi_target: assert property (st_r == ST_ARG && op_r == `CBC_OP_BVI
        && !valid_block_flag |=> pc_r == $past(pc_tgt)) else $error("invalid branch");
    a_bvv_target: assert property (st_r == ST_ARG && op_r == `CBC_OP_BVV
        && valid_block_flag |=> pc_r == $past(pc_tgt)) else $error("valid branch");
    a_skip_branch: assert property (st_r == ST_ARG && is_branch(op_r) && !br_take
        |=> pc_r == $past(pc_r) + PC_W'(2)) else $error("untaken branch skip wrong");
    a_branch_keeps_z: assert property (st_r == ST_ARG && is_branch(op_r) && !cancel_evt
        && !handover_evt && !zero_upd_valid |=> $stable(z_r)) else $error("branch moved zero");
    a_cancel_zero: assert property (cancel_evt && !exec_add && !sw_wr
        |=> z_r == !$past(cancel_done)) else $error("cancel zero wrong");
    a_give_zero: assert property (handover_evt && !cancel_evt && !exec_add && !sw_wr
        |=> z_r == !$past(handover_done)) else $error("handover zero wrong");
    a_cmp_flags: assert property (exec_cmp |=> c_r == ($past(lhs) >= $past(rhs))
        && e_r == ($past(lhs) == $past(rhs)) && $stable(acc_r) && $stable(idx_r))
        else $error("compare flags wrong");
    a_adc_sum: assert property (exec_add |=> acc_r == 8'($past(acc_r) + $past(lct_data)
        + $past(c_r)) && z_r == (acc_r == 8'h00) && s_r == acc_r[7]) else $error("adc wrong");
    a_idx_fetch: assert property (seq_idx_fetch |-> lct_rd && lct_addr == idx_r)
        else $error("indexed table read wrong");
endmodule : cbc_unit
`default_nettype wire

//--- sim/test_channel_branch_compare_unit.sv
/* Self-checking bench of the branch/compare unit over AXI4-Lite.
 * Assumes cbc_cfg.svh, cbc_pkg and cbc_unit are compiled beforehand. */
`default_nettype none
`include "cbc_cfg.svh"
module test_channel_branch_compare_unit;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Signals and stores
    // ----------------------------------------
    logic        clk_sys, reset, vb, zu_v, zu_val, c_evt, c_done, h_evt, h_done;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, prog_rd, lct_rd;
    logic        carry_flag, equal_flag, zero_flag, sign_flag;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, lct_addr, acc_out, idx_out, prog_data, lct_data;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [15:0] prog_addr;
    logic [7:0]  prog_mem [256];
    logic [7:0]  lct_mem [256];
    logic [7:0]  op, base, disp, tgt, lhs, rhs, acc, idx, sum;
    logic        cond, zf, is_vb, taken, one, on_idx, exp_c, exp_e, v, zexp;
    int          n_errors = 0, total_checks = 0, cycles = 0;
    localparam logic [31:0] BOPS = {`CBC_OP_BVV, `CBC_OP_BVI, `CBC_OP_BZ, `CBC_OP_BNZ};
    localparam logic [39:0] COPS = {`CBC_OP_CII, `CBC_OP_CAI, `CBC_OP_CAX, `CBC_OP_CIL,
                                    `CBC_OP_CAL};

    // Stores answer at once; an unstrobed store shows inverted bytes.
    assign prog_data = prog_rd ? prog_mem[prog_addr[7:0]] : ~prog_mem[prog_addr[7:0]];
    assign lct_data  = lct_rd ? lct_mem[lct_addr] : ~lct_mem[lct_addr];

    cbc_unit #(.PC_W(16)) dut (
        .clk_sys, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .prog_addr, .prog_rd, .prog_data,
        .lct_addr, .lct_rd, .lct_data, .valid_block_flag(vb), .zero_upd_valid(zu_v),
        .zero_upd_value(zu_val), .cancel_evt(c_evt), .cancel_done(c_done),
        .handover_evt(h_evt), .handover_done(h_done), .acc_out, .idx_out, .carry_flag,
        .equal_flag, .zero_flag, .sign_flag
    );

    // ----------------------------------------
    // Clock, timeout and reporting
    // ----------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // The ceiling is several times the expected run, so only a hang reaches it.
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            $display("[FAIL] run length expected finish seen hang");
            wrap_up();
        end
    end

    task automatic wrap_up;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // ----------------------------------------
    // Bus tasks
    // ----------------------------------------
    // Each task waits an edge first, so no handshake signal changes twice at once.
    task automatic axi_write(input logic [7:0] a, input logic [31:0] wd, output logic [1:0] rs);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= wd;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge clk_sys);
            if (aw_ok && w_ok && s_axi_bvalid) begin
                rs = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
            if (!aw_ok && s_axi_awready) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_ok && s_axi_wready) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, output logic [31:0] rdat, output logic [1:0] rs);
        logic ar_ok;
        ar_ok = 1'b0;
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge clk_sys);
            if (ar_ok && s_axi_rvalid) begin
                rdat = s_axi_rdata;
                rs = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
            if (!ar_ok && s_axi_arready) begin
                ar_ok = 1'b1;
                s_axi_arvalid <= 1'b0;
            end
        end
    endtask : axi_read

    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        logic [1:0] rs;
        axi_write(a, wd, rs);
        check("write response", {30'h0, rs}, {30'h0, `CBC_RESP_OK});
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] rdat);
        logic [1:0] rs;
        axi_read(a, rdat, rs);
        check("read response", {30'h0, rs}, {30'h0, `CBC_RESP_OK});
    endtask : rd

    // A trap is a two-branch loop on the zero flag; it holds the pointer at a or a+2.
    task automatic set_trap(input logic [7:0] a);
        prog_mem[a] = `CBC_OP_BZ;
        prog_mem[a+8'h1] = 8'hFF;
        prog_mem[a+8'h2] = `CBC_OP_BNZ;
        prog_mem[a+8'h3] = 8'hFD;
    endtask : set_trap

    // Runs from start, halts, and checks that the pointer sits in the expected trap.
    task automatic run_from(input logic [7:0] start, input logic [7:0] trap_at);
        logic [31:0] pd;
        wr(`CBC_REG_PC, {24'h0, start});
        wr(`CBC_REG_CTRL, 32'h1);
        repeat (30) @(posedge clk_sys);
        wr(`CBC_REG_CTRL, 32'h0);
        pd = 32'h1;
        while (pd[`CBC_STAT_BUSY] !== 1'b0) rd(`CBC_REG_STATUS, pd);
        rd(`CBC_REG_PC, pd);
        if (pd === {24'h0, trap_at + 8'h2}) pd = {24'h0, trap_at};
        check("program pointer", pd, {24'h0, trap_at});
    endtask : run_from

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        reset = 1'b1;
        {vb, zu_v, zu_val, c_evt, c_done, h_evt, h_done} = 7'h00;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        for (int i = 0; i < 256; i++) begin
            prog_mem[i] = 8'h00;
            lct_mem[i] = 8'h00;
        end
        repeat (12) @(posedge clk_sys);
        reset <= 1'b0;
        for (int a = 0; a <= 20; a += 4) begin
            rd(8'(a), d);
            check("value after reset", d, 32'h0);
        end
        axi_read(8'h18, d, r);
        check("unmapped read response", {30'h0, r}, {30'h0, `CBC_RESP_ERR});
        check("unmapped read data", d, 32'h0);
        axi_write(8'h18, 32'h1, r);
        check("unmapped write response", {30'h0, r}, {30'h0, `CBC_RESP_ERR});
        set_trap(8'h12); set_trap(8'h22); set_trap(8'h41);
        set_trap(8'h61); set_trap(8'hA0); set_trap(8'hC2);
        // Every branch both ways; the taken cases reach +127 and -128 between them.
        for (int i = 0; i < 8; i++) begin
            op = BOPS[8*(i/2) +: 8];
            cond = 1'(i % 2);
            base = (cond ^ 1'(i / 4)) ? 8'hC0 : 8'h20;
            disp = (base == 8'h20) ? 8'h7F : 8'h80;
            taken = (cond == (op[7:4] == 4'hE));
            is_vb = (op[3:0] == 4'h7);
            prog_mem[base] = op;
            prog_mem[base+8'h1] = disp;
            vb <= is_vb ? cond : ~cond;
            zf = is_vb ? ~cond : cond;
            wr(`CBC_REG_FLAGS, {29'h0, zf, 2'b11});
            tgt = taken ? base + 8'h1 + disp : base + 8'h2;
            run_from(base, tgt);
            rd(`CBC_REG_FLAGS, d);
            check("flags after branch", {28'h0, d[3:0]}, {29'h0, zf, 2'b11});
        end
        // Every compare below, at and above; carry and equal start inverted.
        for (int i = 0; i < 15; i++) begin
            op = COPS[8*(i/3) +: 8];
            lhs = 8'h80;
            rhs = 8'h7F + 8'(i % 3);
            exp_c = (lhs >= rhs);
            exp_e = (lhs == rhs);
            one = (op == `CBC_OP_CAX);
            on_idx = (op == `CBC_OP_CIL) || (op == `CBC_OP_CII);
            base = one ? 8'h60 : 8'h10;
            prog_mem[base] = op;
            if (!one) prog_mem[base+8'h1] = op[7] ? rhs : 8'h05;
            lct_mem[5] = one ? 8'h80 : rhs;
            lct_mem[7] = one ? rhs : 8'h80;
            acc = on_idx ? 8'h33 : lhs;
            idx = on_idx ? lhs : 8'h07;
            wr(`CBC_REG_ACC, {24'h0, acc});
            wr(`CBC_REG_IDX, {24'h0, idx});
            wr(`CBC_REG_FLAGS, {28'h0, 2'b11, ~exp_e, ~exp_c});
            run_from(base, base + (one ? 8'h1 : 8'h2));
            rd(`CBC_REG_FLAGS, d);
            check("compare flags", {30'h0, d[1:0]}, {30'h0, exp_e, exp_c});
            rd(`CBC_REG_ACC, d);
            check("accumulator kept", d, {24'h0, acc});
            rd(`CBC_REG_IDX, d);
            check("index kept", d, {24'h0, idx});
        end
        // Add with carry in; the second case carries out of a zero result.
        for (int i = 0; i < 2; i++) begin
            acc = i ? 8'hFF : 8'h3B;
            rhs = i ? 8'h00 : 8'h44;
            {exp_c, sum} = {1'b0, acc} + {1'b0, rhs} + 9'h1;
            prog_mem[8'h10] = `CBC_OP_ADC;
            prog_mem[8'h11] = 8'h05;
            lct_mem[5] = rhs;
            wr(`CBC_REG_ACC, {24'h0, acc});
            wr(`CBC_REG_FLAGS, {28'h0, ~sum[7], sum != 8'h00, 2'b01});
            run_from(8'h10, 8'h12);
            rd(`CBC_REG_ACC, d);
            check("sum", d, {24'h0, sum});
            rd(`CBC_REG_FLAGS, d);
            check("add flags", {29'h0, d[3:2], d[0]}, {29'h0, sum[7], sum == 8'h00, exp_c});
            check("acc_out", {24'h0, acc_out}, {24'h0, sum});
            check("flag ports", {29'h0, sign_flag, zero_flag, carry_flag},
                  {29'h0, sum[7], sum == 8'h00, exp_c});
        end
        // Cancel, hand-over and outside reports each both ways, zero preset inverted.
        for (int k = 0; k < 6; k++) begin
            v = 1'(k % 2);
            zexp = (k < 4) ? ~v : v;
            wr(`CBC_REG_FLAGS, {29'h0, ~zexp, 2'b00});
            c_evt <= (k < 2);
            h_evt <= (k / 2 == 1);
            zu_v <= (k >= 4);
            {c_done, h_done, zu_val} <= {3{v}};
            @(posedge clk_sys);
            {c_evt, h_evt, zu_v} <= 3'b000;
            repeat (2) @(posedge clk_sys);
            rd(`CBC_REG_FLAGS, d);
            check("zero after event", {31'h0, d[`CBC_FLG_Z]}, {31'h0, zexp});
            check("zero_flag", {31'h0, zero_flag}, {31'h0, zexp});
        end
        wrap_up();
    end
endmodule : test_channel_branch_compare_unit
`default_nettype wire
